//--- logic/tt_xfer_exec.sv
// Purpose: runs peripheral transfer and pin skip instructions over AHB-Lite
// Assumes: timer counts come from logic on hclk; interrupt pins are async
// Notes:   write to the opcode register executes it in that data phase
//
// Contract
// - polarity one: skip when pin zero high
// - polarity zero: skip when pin zero low
// - polarity one: skip when pin one high
// - polarity zero: skip when pin one low
// - read first interrupt control into accumulator
// - write accumulator into first interrupt control
// - second interrupt control read and written, four bits
// - external zero control read and written
// - external one control read and written
// - first timer control read and written
// - second timer control read and written
// - third timer control read and written
// - fourth timer control read and written
// - timer one and reload loaded from pair
// - timer two and reload loaded from pair
// - timer one count read into pair
// - timer two count read into pair
`timescale 1ns/1ns
module tt_xfer_exec (
    // clock and reset
    input  wire  logic        hclk,
    input  wire  logic        hresetn,
    // ahb-lite slave
    input  wire  logic        hsel,
    input  wire  logic [31:0] haddr,
    input  wire  logic [1:0]  htrans,
    input  wire  logic        hwrite,
    input  wire  logic [2:0]  hsize,
    input  wire  logic [31:0] hwdata,
    input  wire  logic        hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // external interrupt pins
    input  wire  logic        ext_int_zero_pin,
    input  wire  logic        ext_int_one_pin,
    // timer hardware
    input  wire  logic [7:0]  timer_one_count,
    input  wire  logic [7:0]  timer_two_count,
    output logic              load_timer_one_pair,
    output logic              load_timer_two_pair,
    output logic [7:0]        timer_load_value,
    // control registers toward interrupt and timer hardware
    output logic [3:0]        int_ctrl_first,
    output logic [3:0]        int_ctrl_second,
    output logic [3:0]        ext_int_zero_ctrl,
    output logic [3:0]        ext_int_one_ctrl,
    output logic [3:0]        timer_ctrl_first,
    output logic [3:0]        timer_ctrl_second,
    output logic [3:0]        timer_ctrl_third,
    output logic [3:0]        timer_ctrl_fourth,
    // skip request to the sequencer
    output logic              skip_next
);

    logic [7:0]  addr_ff;
    logic        wr_pend_ff;
    logic        rd_pend_ff;
    logic        hreadyout_ff;
    logic [31:0] hrdata_ff;
    logic [3:0]  acc_ff;
    logic [3:0]  sec_ff;
    logic [9:0]  opcode_ff;
    logic [3:0]  ctl_ff [8];
    logic        skip_ff;
    logic        skip_next_ff;
    logic        illegal_ff;
    logic        pin0_meta_ff;
    logic        pin0_sync_ff;
    logic        pin1_meta_ff;
    logic        pin1_sync_ff;
    logic        ld1_ff;
    logic        ld2_ff;
    logic [7:0]  ld_val_ff;
    logic        addr_ok;
    logic        exec;
    logic        pin_level;
    logic        pin_pol;
    logic [31:0] nxt_hrdata;

    tt_dec_if dif ();

    tt_decode u_decode (
        .dif (dif.decoder)
    );

    // a data-phase write hit on a given register offset
    function automatic logic wr_hit(input logic [7:0] off);
        return wr_pend_ff && hready && (addr_ff == off);
    endfunction : wr_hit

    // instruction word is taken straight from the write data lanes
    assign dif.opcode = hwdata[9:0];
    assign addr_ok    = hsel && htrans[1] && hready;
    assign exec       = wr_hit(tt_pkg::OFF_OPCODE);

    // address phase capture; reads get one wait state for a fresh value
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            addr_ff      <= 8'h00;
            wr_pend_ff   <= 1'b0;
            rd_pend_ff   <= 1'b0;
            hreadyout_ff <= 1'b1;
        end else if (hready) begin
            wr_pend_ff   <= addr_ok && hwrite;
            rd_pend_ff   <= addr_ok && !hwrite;
            hreadyout_ff <= !(addr_ok && !hwrite);
            if (addr_ok) begin
                addr_ff <= {haddr[7:2], 2'b00}; // word aligned only
            end
        end else begin
            hreadyout_ff <= 1'b1;
        end
    end

    // read mux; unmapped offsets read as zero with an okay answer
    always_comb begin
        nxt_hrdata = 32'h0000_0000;
        unique case (addr_ff)
            tt_pkg::OFF_OPCODE: nxt_hrdata[9:0] = opcode_ff;
            tt_pkg::OFF_ACC:    nxt_hrdata[3:0] = acc_ff;
            tt_pkg::OFF_SEC:    nxt_hrdata[3:0] = sec_ff;
            tt_pkg::OFF_STATUS: begin
                nxt_hrdata[tt_pkg::ST_SKIP]    = skip_ff;
                nxt_hrdata[tt_pkg::ST_ILLEGAL] = illegal_ff;
                nxt_hrdata[tt_pkg::ST_PIN0]    = pin0_sync_ff;
                nxt_hrdata[tt_pkg::ST_PIN1]    = pin1_sync_ff;
            end
            tt_pkg::OFF_CTRLS: nxt_hrdata = {ctl_ff[7], ctl_ff[6], ctl_ff[5],
                                             ctl_ff[4], ctl_ff[3], ctl_ff[2],
                                             ctl_ff[1], ctl_ff[0]};
            tt_pkg::OFF_TCNT: nxt_hrdata[15:0] = {timer_two_count,
                                                  timer_one_count};
            default: nxt_hrdata = 32'h0000_0000;
        endcase
    end

    // read data is loaded during the wait cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_ff <= 32'h0000_0000;
        end else if (rd_pend_ff && !hreadyout_ff) begin
            hrdata_ff <= nxt_hrdata;
        end
    end

    // two-stage synchronisers for the interrupt pins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin0_meta_ff <= 1'b0;
            pin0_sync_ff <= 1'b0;
            pin1_meta_ff <= 1'b0;
            pin1_sync_ff <= 1'b0;
        end else begin
            pin0_meta_ff <= ext_int_zero_pin;
            pin0_sync_ff <= pin0_meta_ff;
            pin1_meta_ff <= ext_int_one_pin;
            pin1_sync_ff <= pin1_meta_ff;
        end
    end

    // selected pin and its polarity bit for the skip test
    assign pin_level = dif.dec.sel[0] ? pin1_sync_ff : pin0_sync_ff;
    assign pin_pol   = dif.dec.sel[0]
                     ? ctl_ff[tt_pkg::CTL_EXT_ONE][tt_pkg::POL_BIT]
                     : ctl_ff[tt_pkg::CTL_EXT_ZERO][tt_pkg::POL_BIT];

    // skip result: pin level equal to polarity means skip
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            skip_ff      <= 1'b0;
            skip_next_ff <= 1'b0;
        end else begin
            skip_next_ff <= 1'b0;
            if (exec) begin
                skip_ff <= 1'b0;
                if (dif.dec.kind == tt_pkg::K_SKIP) begin
                    skip_ff      <= pin_level == pin_pol;
                    skip_next_ff <= pin_level == pin_pol;
                end
            end
        end
    end

    // last instruction word and whether it was outside the group
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            opcode_ff  <= tt_pkg::OPC_RESET;
            illegal_ff <= 1'b0;
        end else if (exec) begin
            opcode_ff  <= hwdata[9:0];
            illegal_ff <= dif.dec.kind == tt_pkg::K_NONE;
        end
    end

    // control registers; loaded from the accumulator on a write instruction
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            for (int i = 0; i < 8; i++) begin
                ctl_ff[i] <= tt_pkg::CTL_RESET;
            end
        end else if (exec && dif.dec.kind == tt_pkg::K_CTL_WR) begin
            ctl_ff[dif.dec.sel] <= acc_ff;
        end
    end

    // accumulator and secondary register; instruction wins over bus write
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            acc_ff <= tt_pkg::NIB_RESET;
            sec_ff <= tt_pkg::NIB_RESET;
        end else if (exec) begin
            case (dif.dec.kind)
                tt_pkg::K_CTL_RD: begin
                    acc_ff <= ctl_ff[dif.dec.sel];
                end
                tt_pkg::K_TMR_RD: begin
                    // high nibble to secondary, low to accumulator
                    {sec_ff, acc_ff} <= dif.dec.sel[0] ? timer_two_count
                                      : timer_one_count;
                end
                default: begin
                    acc_ff <= acc_ff;
                end
            endcase
        end else begin
            if (wr_hit(tt_pkg::OFF_ACC)) begin
                acc_ff <= hwdata[3:0];
            end
            if (wr_hit(tt_pkg::OFF_SEC)) begin
                sec_ff <= hwdata[3:0];
            end
        end
    end

    // timer load strobes; one pulse loads both count and reload register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ld1_ff    <= 1'b0;
            ld2_ff    <= 1'b0;
            ld_val_ff <= 8'h00;
        end else begin
            ld1_ff <= exec && dif.dec.kind == tt_pkg::K_TMR_LD
                   && !dif.dec.sel[0];
            ld2_ff <= exec && dif.dec.kind == tt_pkg::K_TMR_LD
                   && dif.dec.sel[0];
            if (exec && dif.dec.kind == tt_pkg::K_TMR_LD) begin
                ld_val_ff <= {sec_ff, acc_ff};
            end
        end
    end

    // outputs straight from flops, except hresp, which is tied to okay
    assign hreadyout           = hreadyout_ff;
    assign hresp               = 1'b0; // always okay
    assign hrdata              = hrdata_ff;
    assign load_timer_one_pair = ld1_ff;
    assign load_timer_two_pair = ld2_ff;
    assign timer_load_value    = ld_val_ff;
    assign int_ctrl_first      = ctl_ff[tt_pkg::CTL_INT_FIRST];
    assign int_ctrl_second     = ctl_ff[tt_pkg::CTL_INT_SECOND];
    assign ext_int_zero_ctrl   = ctl_ff[tt_pkg::CTL_EXT_ZERO];
    assign ext_int_one_ctrl    = ctl_ff[tt_pkg::CTL_EXT_ONE];
    assign timer_ctrl_first    = ctl_ff[tt_pkg::CTL_TMR_FIRST];
    assign timer_ctrl_second   = ctl_ff[tt_pkg::CTL_TMR_SECOND];
    assign timer_ctrl_third    = ctl_ff[tt_pkg::CTL_TMR_THIRD];
    assign timer_ctrl_fourth   = ctl_ff[tt_pkg::CTL_TMR_FOURTH];
    assign skip_next           = skip_next_ff;

    // checks
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    property p_skip_zero_high;
        exec && dif.opcode == tt_pkg::OPC_SKIP_PIN0
        && ext_int_zero_ctrl[tt_pkg::POL_BIT]
        |=> skip_next == $past(pin0_sync_ff) ##1 !skip_next;
    endproperty
    a_skip_zero_high: assert property (p_skip_zero_high)
        else $error("pin zero high skip wrong");

    property p_skip_zero_low;
        exec && dif.opcode == tt_pkg::OPC_SKIP_PIN0
        && !ext_int_zero_ctrl[tt_pkg::POL_BIT]
        |=> skip_ff != $past(pin0_sync_ff);
    endproperty
    a_skip_zero_low: assert property (p_skip_zero_low)
        else $error("pin zero low skip wrong");

    property p_skip_one;
        exec && dif.opcode == tt_pkg::OPC_SKIP_PIN1
        |=> skip_ff == ($past(pin1_sync_ff)
                        == $past(ext_int_one_ctrl[tt_pkg::POL_BIT]));
    endproperty
    a_skip_one: assert property (p_skip_one)
        else $error("pin one skip wrong");

    property p_rd_first;
        exec && dif.opcode == tt_pkg::OPC_RD_EXT_INT_ONE_PIN
        |=> acc_ff == $past(int_ctrl_first);
    endproperty
    a_rd_first: assert property (p_rd_first)
        else $error("first interrupt control read wrong");

    property p_wr_first;
        exec && dif.opcode == tt_pkg::OPC_WR_EXT_INT_ONE_PIN
        |=> int_ctrl_first == $past(acc_ff);
    endproperty
    a_wr_first: assert property (p_wr_first)
        else $error("first interrupt control write wrong");

    property p_wr_ext_zero;
        exec && dif.opcode == tt_pkg::OPC_WR_EXT0
        |=> ext_int_zero_ctrl == $past(acc_ff);
    endproperty
    a_wr_ext_zero: assert property (p_wr_ext_zero)
        else $error("external zero control write wrong");

    property p_load_one;
        exec && dif.opcode == tt_pkg::OPC_LD_TMR1
        |=> load_timer_one_pair && !load_timer_two_pair
            && timer_load_value == {$past(sec_ff), $past(acc_ff)}
            ##1 !load_timer_one_pair;
    endproperty
    a_load_one: assert property (p_load_one)
        else $error("timer one load wrong");

    property p_read_one;
        exec && dif.opcode == tt_pkg::OPC_RD_TMR1
        |=> sec_ff == $past(timer_one_count[7:4])
            && acc_ff == $past(timer_one_count[3:0]);
    endproperty
    a_read_one: assert property (p_read_one)
        else $error("timer one read wrong");

    property p_bus_read_wait;
        addr_ok && !hwrite |=> !hreadyout ##1 hreadyout;
    endproperty
    a_bus_read_wait: assert property (p_bus_read_wait)
        else $error("read answer timing wrong");

    c_skip_taken: cover property (exec && dif.dec.kind == tt_pkg::K_SKIP
                                  ##1 skip_next);
    c_load_two:   cover property (load_timer_two_pair);
    c_ctl_write:  cover property (exec
                                  && dif.dec.kind == tt_pkg::K_CTL_WR);
    c_illegal:    cover property (illegal_ff);

endmodule : tt_xfer_exec

//--- logic/tt_pkg.sv
// Purpose: shared constants and types for the transfer execution block
// Assumes: 10-bit instruction words, 4-bit accumulator and secondary reg
// Notes:   register offsets are byte addresses on a 32-bit bus
package tt_pkg;

    // bus register offsets
    localparam logic [7:0] OFF_OPCODE = 8'h00; // write runs an instruction
    localparam logic [7:0] OFF_ACC    = 8'h04;
    localparam logic [7:0] OFF_SEC    = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0c;
    localparam logic [7:0] OFF_CTRLS  = 8'h10; // all eight controls packed
    localparam logic [7:0] OFF_TCNT   = 8'h14; // both timer counts

    // status field positions
    localparam int ST_SKIP    = 0;
    localparam int ST_ILLEGAL = 1;
    localparam int ST_PIN0    = 2;
    localparam int ST_PIN1    = 3;

    // polarity bit inside each external interrupt control register
    localparam int POL_BIT = 2;

    // control register indexes
    localparam logic [2:0] CTL_INT_FIRST  = 3'h0;
    localparam logic [2:0] CTL_INT_SECOND = 3'h1;
    localparam logic [2:0] CTL_EXT_ZERO   = 3'h2;
    localparam logic [2:0] CTL_EXT_ONE    = 3'h3;
    localparam logic [2:0] CTL_TMR_FIRST  = 3'h4;
    localparam logic [2:0] CTL_TMR_SECOND = 3'h5;
    localparam logic [2:0] CTL_TMR_THIRD  = 3'h6;
    localparam logic [2:0] CTL_TMR_FOURTH = 3'h7;

    // reset values
    localparam logic [3:0] CTL_RESET = 4'h0;
    localparam logic [3:0] NIB_RESET = 4'h0;
    localparam logic [9:0] OPC_RESET = 10'h000;

    // instruction codes
    localparam logic [9:0] OPC_SKIP_PIN0  = 10'h03a;
    localparam logic [9:0] OPC_SKIP_PIN1  = 10'h03b;
    localparam logic [9:0] OPC_RD_EXT_INT_ONE_PIN    = 10'h054;
    localparam logic [9:0] OPC_WR_EXT_INT_ONE_PIN    = 10'h03f;
    localparam logic [9:0] OPC_RD_INT2    = 10'h055;
    localparam logic [9:0] OPC_WR_INT2    = 10'h03e;
    localparam logic [9:0] OPC_RD_EXT0    = 10'h253;
    localparam logic [9:0] OPC_WR_EXT0    = 10'h217;
    localparam logic [9:0] OPC_RD_EXT1    = 10'h254;
    localparam logic [9:0] OPC_WR_EXT1    = 10'h218;
    localparam logic [9:0] OPC_RD_TMC1    = 10'h24b;
    localparam logic [9:0] OPC_WR_TMC1    = 10'h20e;
    localparam logic [9:0] OPC_RD_TMC2    = 10'h24c;
    localparam logic [9:0] OPC_WR_TMC2    = 10'h20f;
    localparam logic [9:0] OPC_RD_TMC3    = 10'h24d;
    localparam logic [9:0] OPC_WR_TMC3    = 10'h210;
    localparam logic [9:0] OPC_RD_TMC4    = 10'h24e;
    localparam logic [9:0] OPC_WR_TMC4    = 10'h211;
    localparam logic [9:0] OPC_RD_TMR1    = 10'h270;
    localparam logic [9:0] OPC_LD_TMR1    = 10'h230;
    localparam logic [9:0] OPC_RD_TMR2    = 10'h271;
    localparam logic [9:0] OPC_LD_TMR2    = 10'h231;

    // instruction classes
    typedef enum logic [2:0] {
        K_NONE    = 3'h0,
        K_SKIP    = 3'h1,
        K_CTL_RD  = 3'h2,
        K_CTL_WR  = 3'h3,
        K_TMR_LD  = 3'h4,
        K_TMR_RD  = 3'h5
    } tt_kind_e;

    // decoded instruction: class plus register, timer or pin select
    typedef struct packed {
        tt_kind_e   kind;
        logic [2:0] sel;
    } tt_dec_s;

endpackage : tt_pkg

//--- logic/tt_dec_if.sv
// Purpose: carries an instruction word to the decoder and its result back
// Assumes: decoder is purely combinational
// Notes:   none
`timescale 1ns/1ns
interface tt_dec_if;
    logic [9:0]       opcode;
    tt_pkg::tt_dec_s  dec;

    modport decoder (input opcode, output dec);
    modport user    (output opcode, input dec);
endinterface : tt_dec_if

//--- logic/tt_decode.sv
// Purpose: maps a 10-bit instruction word to class and select
// Assumes: unknown words give class none
// Notes:   combinational, no state
`timescale 1ns/1ns
module tt_decode (
    // decode channel
    tt_dec_if.decoder dif
);

    // table lookup; every word of the group is one instruction word
    function automatic tt_pkg::tt_dec_s decode(input logic [9:0] w);
        tt_pkg::tt_dec_s d;
        d = '{kind: tt_pkg::K_NONE, sel: 3'h0};
        unique case (w)
            tt_pkg::OPC_SKIP_PIN0: d = '{tt_pkg::K_SKIP, 3'h0};
            tt_pkg::OPC_SKIP_PIN1: d = '{tt_pkg::K_SKIP, 3'h1};
            tt_pkg::OPC_RD_EXT_INT_ONE_PIN: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_INT_FIRST};
            tt_pkg::OPC_WR_EXT_INT_ONE_PIN: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_INT_FIRST};
            tt_pkg::OPC_RD_INT2: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_INT_SECOND};
            tt_pkg::OPC_WR_INT2: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_INT_SECOND};
            tt_pkg::OPC_RD_EXT0: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_EXT_ZERO};
            tt_pkg::OPC_WR_EXT0: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_EXT_ZERO};
            tt_pkg::OPC_RD_EXT1: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_EXT_ONE};
            tt_pkg::OPC_WR_EXT1: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_EXT_ONE};
            tt_pkg::OPC_RD_TMC1: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_TMR_FIRST};
            tt_pkg::OPC_WR_TMC1: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_TMR_FIRST};
            tt_pkg::OPC_RD_TMC2: d = '{tt_pkg::K_CTL_RD,
                                       tt_pkg::CTL_TMR_SECOND};
            tt_pkg::OPC_WR_TMC2: d = '{tt_pkg::K_CTL_WR,
                                       tt_pkg::CTL_TMR_SECOND};
            tt_pkg::OPC_RD_TMC3: d = '{tt_pkg::K_CTL_RD, tt_pkg::CTL_TMR_THIRD};
            tt_pkg::OPC_WR_TMC3: d = '{tt_pkg::K_CTL_WR, tt_pkg::CTL_TMR_THIRD};
            tt_pkg::OPC_RD_TMC4: d = '{tt_pkg::K_CTL_RD,
                                       tt_pkg::CTL_TMR_FOURTH};
            tt_pkg::OPC_WR_TMC4: d = '{tt_pkg::K_CTL_WR,
                                       tt_pkg::CTL_TMR_FOURTH};
            tt_pkg::OPC_LD_TMR1: d = '{tt_pkg::K_TMR_LD, 3'h0};
            tt_pkg::OPC_LD_TMR2: d = '{tt_pkg::K_TMR_LD, 3'h1};
            tt_pkg::OPC_RD_TMR1: d = '{tt_pkg::K_TMR_RD, 3'h0};
            tt_pkg::OPC_RD_TMR2: d = '{tt_pkg::K_TMR_RD, 3'h1};
            default: d = '{kind: tt_pkg::K_NONE, sel: 3'h0};
        endcase
        return d;
    endfunction : decode

    // decode the word presented by the executing side
    always_comb begin
        dif.dec = decode(dif.opcode);
    end

endmodule : tt_decode

//--- tb/tt_timer_model.sv
// Purpose: stand-in for timers one and two and their reload registers
// Assumes: load pulses are one cycle wide on hclk
// Notes:   counts hold between loads so read-back is predictable
`timescale 1ns/1ns
module tt_timer_model (
    // clock and reset
    input  wire logic       hclk,
    input  wire logic       hresetn,
    // load requests from the block
    input  wire logic       load_one,
    input  wire logic       load_two,
    input  wire logic [7:0] value,
    // counts and reload registers
    output logic [7:0]      count_one_ff,
    output logic [7:0]      count_two_ff,
    output logic [7:0]      reload_one_ff,
    output logic [7:0]      reload_two_ff
);
    // one pulse loads count and reload together
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            count_one_ff  <= 8'h00;
            count_two_ff  <= 8'h00;
            reload_one_ff <= 8'h00;
            reload_two_ff <= 8'h00;
        end else begin
            if (load_one) begin
                count_one_ff  <= value;
                reload_one_ff <= value;
            end
            if (load_two) begin
                count_two_ff  <= value;
                reload_two_ff <= value;
            end
        end
    end
endmodule : tt_timer_model

//--- tb/tt_xfer_exec_test.sv
// Purpose: self-checking bench for the transfer execution block
// Assumes: single bus master, hready looped from hreadyout
// Notes:   read results are matched against a queue of expectations
`timescale 1ns/1ns
module tt_xfer_exec_test;
    logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, skip_next;
    logic        pin0, pin1, ld1, ld2;
    logic        rd_pend = 1'b0;
    logic [1:0]  htrans;
    logic [31:0] haddr, hwdata, hrdata, exp_ctl, v;
    wire  [31:0] ctl_out; // eight port-driven nibbles, so a net
    logic [7:0]  tval, cnt1, cnt2, rl1, rl2;
    logic [7:0]  t[2];
    logic [31:0] q[$];
    logic        p, pol, pn, a0, a1;
    int          err_count, total_checks, seed, skip_exp, skip_seen, i;
    logic [9:0]  wop[8] = '{tt_pkg::OPC_WR_EXT_INT_ONE_PIN, tt_pkg::OPC_WR_INT2,
        tt_pkg::OPC_WR_EXT0, tt_pkg::OPC_WR_EXT1, tt_pkg::OPC_WR_TMC1,
        tt_pkg::OPC_WR_TMC2, tt_pkg::OPC_WR_TMC3, tt_pkg::OPC_WR_TMC4};
    logic [9:0]  rop[8] = '{tt_pkg::OPC_RD_EXT_INT_ONE_PIN, tt_pkg::OPC_RD_INT2,
        tt_pkg::OPC_RD_EXT0, tt_pkg::OPC_RD_EXT1, tt_pkg::OPC_RD_TMC1,
        tt_pkg::OPC_RD_TMC2, tt_pkg::OPC_RD_TMC3, tt_pkg::OPC_RD_TMC4};

    tt_xfer_exec dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .ext_int_zero_pin(pin0),
        .ext_int_one_pin(pin1), .timer_one_count(cnt1),
        .timer_two_count(cnt2), .load_timer_one_pair(ld1),
        .load_timer_two_pair(ld2), .timer_load_value(tval),
        .int_ctrl_first(ctl_out[3:0]), .int_ctrl_second(ctl_out[7:4]),
        .ext_int_zero_ctrl(ctl_out[11:8]), .ext_int_one_ctrl(ctl_out[15:12]),
        .timer_ctrl_first(ctl_out[19:16]), .timer_ctrl_second(ctl_out[23:20]),
        .timer_ctrl_third(ctl_out[27:24]), .timer_ctrl_fourth(ctl_out[31:28]),
        .skip_next(skip_next));

    tt_timer_model tmr (.hclk(hclk), .hresetn(hresetn), .load_one(ld1),
        .load_two(ld2), .value(tval), .count_one_ff(cnt1),
        .count_two_ff(cnt2), .reload_one_ff(rl1), .reload_two_ff(rl2));

    task automatic chk(input string n, input logic [31:0] e, s);
        total_checks++;
        if (s !== e) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", n, e, s);
        end
    endtask : chk

    // single transfer; address held until taken, data until answered
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        hwrite <= w;
        haddr  <= {24'h000000, a};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        q.push_back(e);
        bus(1'b0, a, 32'h00000000);
    endtask : rd

    task automatic end_sim;
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : end_sim

    // monitor: read data taken where the read data phase completes
    always @(posedge hclk) begin
        if (skip_next === 1'b1) skip_seen++;
        if (rd_pend === 1'b1 && hreadyout === 1'b1) begin
            chk("hrdata", q.pop_front(), hrdata);
            chk("hresp", 32'h0, {31'h0, hresp});
        end
        if (hreadyout === 1'b1) rd_pend <= hsel & htrans[1] & ~hwrite;
    end

    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // hang guard well above the few hundred cycles the run needs
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        $display("MISMATCH timeout exp done got hang");
        end_sim;
    end

    initial begin
        {hresetn, hsel, hwrite, pin0, pin1} = 5'h00;
        {htrans, haddr, hwdata} = '0;
        seed = 10;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        rd(tt_pkg::OFF_CTRLS, 32'h00000000);
        rd(tt_pkg::OFF_ACC, 32'h00000000);
        // write every control from a random nibble, then read each back
        for (i = 0; i < 8; i++) begin
            v = $random(seed);
            exp_ctl[i*4 +: 4] = v[3:0];
            bus(1'b1, tt_pkg::OFF_ACC, {28'h0, v[3:0]});
            bus(1'b1, tt_pkg::OFF_OPCODE, {22'h0, wop[i]});
        end
        // last write lands at the edge the task returned on
        @(posedge hclk);
        chk("ctl outputs", exp_ctl, ctl_out);
        for (i = 0; i < 8; i++) begin
            bus(1'b1, tt_pkg::OFF_ACC, {28'h0, ~exp_ctl[i*4 +: 4]});
            bus(1'b1, tt_pkg::OFF_OPCODE, {22'h0, rop[i]});
            rd(tt_pkg::OFF_ACC, {28'h0, exp_ctl[i*4 +: 4]});
        end
        rd(tt_pkg::OFF_CTRLS, exp_ctl);
        // every pin, polarity and level; other pin held opposite
        for (i = 0; i < 8; i++) begin
            {pn, pol, p} = i[2:0];
            a0 = pn ? ~p : p;
            a1 = pn ? p : ~p;
            pin0 <= a0;
            pin1 <= a1;
            exp_ctl[(pn ? 12 : 8) +: 4] = {1'b0, pol, 2'b00};
            bus(1'b1, tt_pkg::OFF_ACC, {29'h0, pol, 2'b00});
            bus(1'b1, tt_pkg::OFF_OPCODE,
                {22'h0, pn ? tt_pkg::OPC_WR_EXT1 : tt_pkg::OPC_WR_EXT0});
            bus(1'b1, tt_pkg::OFF_OPCODE,
                {22'h0, pn ? tt_pkg::OPC_SKIP_PIN1 : tt_pkg::OPC_SKIP_PIN0});
            skip_exp += (p == pol);
            rd(tt_pkg::OFF_STATUS, {28'h0, a1, a0, 1'b0, p == pol});
        end
        // load both timers from the pair, then read counts back
        for (i = 0; i < 2; i++) begin
            v = $random(seed);
            t[i] = v[7:0];
            bus(1'b1, tt_pkg::OFF_SEC, {28'h0, v[7:4]});
            bus(1'b1, tt_pkg::OFF_ACC, {28'h0, v[3:0]});
            bus(1'b1, tt_pkg::OFF_OPCODE,
                {22'h0, i ? tt_pkg::OPC_LD_TMR2 : tt_pkg::OPC_LD_TMR1});
            @(posedge hclk);
            #1;
            chk("reload", {24'h0, t[i]}, {24'h0, i ? rl2 : rl1});
        end
        rd(tt_pkg::OFF_TCNT, {16'h0, t[1], t[0]});
        for (i = 0; i < 2; i++) begin
            bus(1'b1, tt_pkg::OFF_OPCODE,
                {22'h0, i ? tt_pkg::OPC_RD_TMR2 : tt_pkg::OPC_RD_TMR1});
            rd(tt_pkg::OFF_SEC, {28'h0, t[i][7:4]});
            rd(tt_pkg::OFF_ACC, {28'h0, t[i][3:0]});
        end
        // unknown word leaves state alone and clears the skip result
        bus(1'b1, tt_pkg::OFF_OPCODE, 32'h000003ff);
        rd(tt_pkg::OFF_STATUS, {28'h0, a1, a0, 2'b10});
        rd(tt_pkg::OFF_OPCODE, 32'h000003ff);
        rd(8'h20, 32'h00000000);
        rd(tt_pkg::OFF_CTRLS, exp_ctl);
        repeat (2) @(posedge hclk);
        chk("skip pulses", skip_exp, skip_seen);
        end_sim;
    end
endmodule : tt_xfer_exec_test
